// *** verilog/uhct_cfg.svh ***
// uhct constants: register offsets, field positions, codes, reset values
`ifndef UHCT_CFG_SVH
`define UHCT_CFG_SVH
`define UHCT_CH_STRIDE 12'h010
`define UHCT_REG_CFG 2'h0
`define UHCT_REG_MPS 2'h1
`define UHCT_REG_TOT 2'h2
`define UHCT_REG_STA 2'h3
`define UHCT_ENG_ADDR 12'h100
`define UHCT_CFG_GO 0
`define UHCT_CFG_TIN 1
`define UHCT_CFG_KLO 2
`define UHCT_STA_ACK 0
`define UHCT_STA_ERR 1
`define UHCT_STA_HALT 2
`define UHCT_STA_RLO 4
`define UHCT_RST_MPS 16'h0040
`define UHCT_RC_NONE 4'h0
`define UHCT_RC_STALL 4'h1
`define UHCT_RC_RETRY 4'h2
`define UHCT_RC_SHORT 4'h3
`define UHCT_RC_BABBLE 4'h4
`define UHCT_RC_STARVE 4'h5
`define UHCT_RETRY_LAST 2'h2
`define UHCT_RESP_OKAY 2'h0
`define UHCT_RESP_SLVERR 2'h2
`endif

// *** verilog/uhct_pkg.sv ***
// uhct types: engine states, transfer kinds, link outcomes
package uhct_pkg;
    // engine sequencer states
    typedef enum logic {UHCT_IDLE, UHCT_WAIT} uhct_state_e;
    // transfer kind field values
    typedef enum logic [1:0] {
        UHCT_BULK = 2'h0,
        UHCT_INTR = 2'h1,
        UHCT_ISO = 2'h2
    } uhct_kind_e;
    // outcome of one bus transaction, reported by the link
    typedef enum logic [2:0] {
        UHCT_LK_ACK = 3'h0,
        UHCT_LK_NAK = 3'h1,
        UHCT_LK_STALL = 3'h2,
        UHCT_LK_ERR = 3'h3,
        UHCT_LK_SHORT = 3'h4,
        UHCT_LK_BABBLE = 3'h5,
        UHCT_LK_TOGGLE = 3'h6
    } uhct_link_t;
endpackage

// *** verilog/uhct_engine.sv ***
// uhct transaction engine: per-channel out/in transactions, axi4-lite regs
//
// Contract
// - bulk out checks fifo data, frame time
// - bulk-only channel has no kind field
// - packet length is min(max packet, total)
// - out ack: set ack flag, free fifo
// - out nak: fifo kept, same transaction again
// - out stall: stop, stall code, halt flag
// - out no handshake: retry code, error flag
// - three retry faults stop transfer, halt flag
// - intr/iso out general only, check interval
// - iso out: ack flag, free, no handshake
// - iso out starved: skip, starve code, error
// - bulk in checks fifo space, frame time
// - bulk in good: send ack, flag, reserve
// - short in: ack, stop, short code, keep
// - in nak: no flag, fifo unchanged
// - in stall: stop, stall code, halt flag
// - in babble: no ack, stop, halt
// - toggle mismatch: ack, discard, retry error
// - in bus errors: no ack, retry error
// - out token then data to endpoint
// - in token, data back, then ack
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "uhct_cfg.svh"
module uhct_engine #(
    parameter int NCH = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // scheduler pick, same clock
    input wire logic sched_pick,
    input wire logic [$clog2(NCH)-1:0] sched_chan,
    input wire logic frame_room_ok,
    input wire logic interval_ok,
    // occupancy of the picked channel's fifo
    input wire logic [15:0] fifo_valid_bytes,
    input wire logic [15:0] fifo_free_bytes,
    // transaction request to the packet link
    output logic tx_start,
    output logic tx_token_in,
    output logic tx_iso,
    output logic [$clog2(NCH)-1:0] tx_chan,
    output logic [15:0] tx_len,
    // outcome from the packet link, and the ack sent back to it
    input wire logic lk_done,
    input wire uhct_pkg::uhct_link_t lk_res,
    input wire logic [15:0] lk_len,
    output logic hs_send_ack,
    // fifo update: free after out, reserve after in
    output logic fifo_upd,
    output logic [$clog2(NCH)-1:0] fifo_upd_chan,
    output logic [15:0] fifo_upd_bytes
);
    import uhct_pkg::*;

    localparam int CW = $clog2(NCH);

    // every register and pulse of the block in one record
    typedef struct packed {
        logic [NCH-1:0] go; // transfer_go per channel
        logic [NCH-1:0] tin; // token_kind_field, 1 = in
        logic [NCH-1:0][1:0] kind; // transfer_kind_field
        logic [NCH-1:0][15:0] mps; // max_packet_bytes
        logic [NCH-1:0][31:0] tot; // total_transfer_bytes left
        logic [NCH-1:0][2:0] flg; // ack, error, halt notice
        logic [NCH-1:0][3:0] rsn; // result_reason_code
        logic [NCH-1:0][1:0] rty; // consecutive retry faults
        uhct_state_e st; // sequencer
        logic [CW-1:0] ch; // channel in flight
        logic [15:0] len; // packet length in flight
        logic in; // in flight is an in
        logic iso; // in flight is iso
        logic txs; // tx_start pulse
        logic ack; // hs_send_ack pulse
        logic upd; // fifo_upd pulse
        logic [15:0] updb; // fifo_upd_bytes
        logic awg; // write address held
        logic [11:0] awa;
        logic wg; // write data held
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } uhct_st_s;

    uhct_st_s s;
    uhct_st_s next_s;

    // handshake readies; a frozen block takes nothing
    assign s_axi_awready = ce && !s.awg && !s.bv;
    assign s_axi_wready = ce && !s.wg && !s.bv;
    assign s_axi_arready = ce && !s.rv;
    assign s_axi_bvalid = s.bv;
    assign s_axi_bresp = s.br;
    assign s_axi_rvalid = s.rv;
    assign s_axi_rdata = s.rd;
    assign s_axi_rresp = s.rr;
    assign tx_start = s.txs;
    assign tx_token_in = s.in;
    assign tx_iso = s.iso;
    assign tx_chan = s.ch;
    assign tx_len = s.len;
    assign hs_send_ack = s.ack;
    assign fifo_upd = s.upd;
    assign fifo_upd_chan = s.ch;
    assign fifo_upd_bytes = s.updb;

    // register read mux
    function automatic logic [32:0] rdmux(input uhct_st_s r,
                                          input logic [11:0] a);
        logic [31:0] v;
        logic hit;
        int c;
        v = 32'h0000_0000;
        hit = 1'b0;
        c = int'(a[11:4]);
        if (a == `UHCT_ENG_ADDR) begin
            hit = 1'b1;
            v[15:8] = 8'(r.ch);
            v[7:0] = {6'h00, r.in, r.st};
        end else if (c < NCH) begin
            hit = 1'b1;
            case (a[3:2])
                `UHCT_REG_CFG: begin
                    v[`UHCT_CFG_GO] = r.go[c];
                    v[`UHCT_CFG_TIN] = r.tin[c];
                    v[`UHCT_CFG_KLO+:2] = r.kind[c];
                end
                `UHCT_REG_MPS: v[15:0] = r.mps[c];
                `UHCT_REG_TOT: v = r.tot[c];
                default: begin
                    v[2:0] = r.flg[c];
                    v[`UHCT_STA_RLO+:4] = r.rsn[c];
                end
            endcase
        end
        return {hit, v};
    endfunction

    // retry fault: count it and give up on the third in a row
    function automatic uhct_st_s fault(input uhct_st_s r,
                                       input logic [CW-1:0] c);
        uhct_st_s q;
        q = r;
        q.rsn[c] = `UHCT_RC_RETRY;
        q.flg[c][`UHCT_STA_ERR] = 1'b1;
        if (r.rty[c] == `UHCT_RETRY_LAST) begin
            q.go[c] = 1'b0;
            q.flg[c][`UHCT_STA_HALT] = 1'b1;
            q.rty[c] = 2'h0;
        end else begin
            q.rty[c] = r.rty[c] + 2'h1;
        end
        return q;
    endfunction

    // stop the transfer with a reason and a halt notice
    function automatic uhct_st_s halt(input uhct_st_s r,
                                      input logic [CW-1:0] c,
                                      input logic [3:0] code);
        uhct_st_s q;
        q = r;
        q.go[c] = 1'b0;
        q.rsn[c] = code;
        q.flg[c][`UHCT_STA_HALT] = 1'b1;
        q.rty[c] = 2'h0;
        return q;
    endfunction

    // next state: bus slave first, engine second so hardware sets win
    always_comb begin
        logic [32:0] rm;
        logic [31:0] wv;
        logic [15:0] plen;
        logic [CW-1:0] c;
        logic ok;
        int wc;
        next_s = s;
        rm = 33'h0;
        wv = 32'h0000_0000;
        plen = 16'h0000;
        c = s.ch;
        ok = 1'b0;
        wc = 0;
        next_s.txs = 1'b0;
        next_s.ack = 1'b0;
        next_s.upd = 1'b0;
        // capture write address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_s.awg = 1'b1;
            next_s.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_s.wg = 1'b1;
            next_s.wd = s_axi_wdata;
            next_s.ws = s_axi_wstrb;
        end
        if (s.bv && s_axi_bready) begin
            next_s.bv = 1'b0;
        end
        // commit a write once both halves are held
        if (s.awg && s.wg) begin
            next_s.awg = 1'b0;
            next_s.wg = 1'b0;
            next_s.bv = 1'b1;
            rm = rdmux(s, s.awa);
            next_s.br = rm[32] ? `UHCT_RESP_OKAY : `UHCT_RESP_SLVERR;
            wc = int'(s.awa[11:4]);
            for (int b = 0; b < 4; b++) begin
                wv[b*8+:8] = s.ws[b] ? s.wd[b*8+:8] : rm[b*8+:8];
            end
            if (rm[32] && s.awa != `UHCT_ENG_ADDR) begin
                case (s.awa[3:2])
                    `UHCT_REG_CFG: begin
                        next_s.go[wc] = wv[`UHCT_CFG_GO];
                        next_s.tin[wc] = wv[`UHCT_CFG_TIN];
                        // channel 0 is the bulk-only channel
                        next_s.kind[wc] = (wc == 0) ? UHCT_BULK :
                            wv[`UHCT_CFG_KLO+:2];
                        if (wv[`UHCT_CFG_GO]) begin
                            next_s.rty[wc] = 2'h0;
                        end
                    end
                    `UHCT_REG_MPS: next_s.mps[wc] = wv[15:0];
                    `UHCT_REG_TOT: next_s.tot[wc] = wv;
                    // write one to clear a flag
                    default: next_s.flg[wc] = s.flg[wc] & ~wv[2:0];
                endcase
            end
        end
        // reads answer one cycle after the address is taken
        if (s.rv && s_axi_rready) begin
            next_s.rv = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rm = rdmux(s, s_axi_araddr);
            next_s.rv = 1'b1;
            next_s.rd = rm[31:0];
            next_s.rr = rm[32] ? `UHCT_RESP_OKAY : `UHCT_RESP_SLVERR;
        end
        // engine
        case (s.st)
            UHCT_IDLE: begin
                c = sched_chan;
                if (sched_pick && int'(c) < NCH && s.go[c]) begin
                    // smaller of max packet and what is left
                    plen = (s.tot[c] < {16'h0000, s.mps[c]}) ?
                        s.tot[c][15:0] : s.mps[c];
                    if (s.tin[c]) begin
                        // only bulk in runs here
                        ok = frame_room_ok && fifo_free_bytes >= plen &&
                            s.kind[c] == UHCT_BULK;
                    end else if (s.kind[c] == UHCT_ISO &&
                                 fifo_valid_bytes < plen) begin
                        next_s.flg[c][`UHCT_STA_ERR] = 1'b1;
                        next_s.rsn[c] = `UHCT_RC_STARVE;
                    end else begin
                        // periodic kinds also wait for their interval
                        ok = frame_room_ok &&
                            fifo_valid_bytes >= plen &&
                            (s.kind[c] == UHCT_BULK ||
                             interval_ok);
                    end
                    if (ok) begin
                        // link sends token, then data or waits for it
                        next_s.txs = 1'b1;
                        next_s.st = UHCT_WAIT;
                        next_s.ch = c;
                        next_s.len = plen;
                        next_s.in = s.tin[c];
                        next_s.iso = s.kind[c] == UHCT_ISO;
                    end
                end
            end
            UHCT_WAIT: begin
                if (lk_done) begin
                    next_s.st = UHCT_IDLE;
                    if (!s.in && (s.iso || lk_res == UHCT_LK_ACK)) begin
                        // iso needs no handshake to count as sent
                        next_s.flg[c][`UHCT_STA_ACK] = 1'b1;
                        next_s.upd = 1'b1;
                        next_s.updb = s.len;
                        next_s.tot[c] = s.tot[c] - 32'(s.len);
                        next_s.rty[c] = 2'h0;
                    end else if (!s.in) begin
                        case (lk_res)
                            UHCT_LK_NAK: ;   // fifo kept, retried
                            UHCT_LK_STALL:
                                next_s = halt(next_s, c,
                                    `UHCT_RC_STALL);
                            default: next_s = fault(next_s, c);
                        endcase
                    end else begin
                        case (lk_res)
                            UHCT_LK_ACK: begin
                                next_s.ack = 1'b1;
                                next_s.flg[c][`UHCT_STA_ACK] = 1'b1;
                                next_s.upd = 1'b1;
                                next_s.updb = s.len;
                                next_s.tot[c] = s.tot[c] - 32'(s.len);
                                next_s.rty[c] = 2'h0;
                            end
                            UHCT_LK_SHORT: begin
                                // short data still lands in the fifo
                                next_s = halt(next_s, c,
                                    `UHCT_RC_SHORT);
                                next_s.ack = 1'b1;
                                next_s.upd = 1'b1;
                                next_s.updb = lk_len;
                                next_s.tot[c] = s.tot[c] - 32'(lk_len);
                            end
                            UHCT_LK_NAK: ;   // silent
                            UHCT_LK_STALL:
                                next_s = halt(next_s, c,
                                    `UHCT_RC_STALL);
                            UHCT_LK_BABBLE:
                                next_s = halt(next_s, c,
                                    `UHCT_RC_BABBLE);
                            UHCT_LK_TOGGLE: begin
                                // ack so the endpoint moves on, drop data
                                next_s.ack = 1'b1;
                                next_s = fault(next_s, c);
                            end
                            default: next_s = fault(next_s, c);
                        endcase
                    end
                end
            end
            default: next_s.st = UHCT_IDLE;
        endcase
    end

    // state register; synchronous reset, clock enable freezes all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            for (int i = 0; i < NCH; i++) begin
                s.mps[i] <= `UHCT_RST_MPS;
            end
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule

// *** bench/uhct_engine_monitor.sv ***
// assertion checker bound to the transaction engine
`timescale 1ns/1ps
module uhct_engine_monitor #(
    parameter int NCH = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sched_pick,
    input wire logic tx_start,
    input wire logic tx_token_in,
    input wire logic tx_iso,
    input wire logic [$clog2(NCH)-1:0] tx_chan,
    input wire logic [15:0] tx_len,
    input wire logic lk_done,
    input wire uhct_pkg::uhct_link_t lk_res,
    input wire logic [15:0] lk_len,
    input wire logic hs_send_ack,
    input wire logic fifo_upd,
    input wire logic [15:0] fifo_upd_bytes
);
    import uhct_pkg::*;
    logic busy; // a transaction is out on the link
    // busy spans the wait between token and outcome
    always_ff @(posedge aclk) begin
        if (!aresetn || lk_done) begin
            busy <= 1'b0;
        end else if (tx_start) begin
            busy <= 1'b1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_start_after_pick: assert property (tx_start |-> $past(sched_pick))
        else $error("tx_start without a pick");
    a_req_stable: assert property (busy |-> $stable(tx_len) &&
        $stable(tx_chan) && $stable(tx_token_in))
        else $error("request moved while on the link");
    a_upd_cause: assert property (fifo_upd |-> $past(lk_done))
        else $error("fifo update without an outcome");
    a_nak_keep: assert property (lk_done && lk_res == UHCT_LK_NAK &&
        !tx_iso |=> !fifo_upd && !hs_send_ack)
        else $error("nak changed the fifo");
    a_out_free: assert property (lk_done && !tx_token_in &&
        (lk_res == UHCT_LK_ACK || tx_iso) |=>
        fifo_upd && fifo_upd_bytes == $past(tx_len))
        else $error("out data not freed");
    a_out_no_hs: assert property (lk_done && !tx_token_in |=> !hs_send_ack)
        else $error("handshake sent on out");
    a_in_ack: assert property (lk_done && tx_token_in &&
        lk_res == UHCT_LK_ACK |=> hs_send_ack && fifo_upd &&
        fifo_upd_bytes == $past(tx_len))
        else $error("good in packet mishandled");
    a_short_keep: assert property (lk_done && tx_token_in &&
        lk_res == UHCT_LK_SHORT |=> hs_send_ack && fifo_upd &&
        fifo_upd_bytes == $past(lk_len))
        else $error("short in packet mishandled");
    a_toggle_drop: assert property (lk_done && tx_token_in &&
        lk_res == UHCT_LK_TOGGLE |=> hs_send_ack && !fifo_upd)
        else $error("toggle mismatch mishandled");
    a_bad_silent: assert property (lk_done && tx_token_in &&
        lk_res inside {UHCT_LK_ERR, UHCT_LK_BABBLE, UHCT_LK_STALL} |=>
        !hs_send_ack && !fifo_upd)
        else $error("failed in packet answered or kept");
endmodule
bind uhct_engine uhct_engine_monitor #(.NCH(NCH)) u_mon (
    .aclk, .aresetn, .sched_pick, .tx_start, .tx_token_in, .tx_iso,
    .tx_chan, .tx_len, .lk_done, .lk_res, .lk_len, .hs_send_ack,
    .fifo_upd, .fifo_upd_bytes
);

// *** bench/uhct_endpoint_model.sv ***
// usb endpoint model: answers each token after a set number of cycles
`timescale 1ns/1ps
module uhct_endpoint_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tx_start,
    input wire uhct_pkg::uhct_link_t cmd_res,
    input wire logic [15:0] cmd_len,
    input wire logic [3:0] cmd_wait,
    output logic busy,
    output logic lk_done,
    output uhct_pkg::uhct_link_t lk_res,
    output logic [15:0] lk_len
);
    import uhct_pkg::*;
    logic [3:0] cnt; // cycles left before the answer
    // outside the answer the result lines wander, so stale values never help
    always @(posedge aclk) begin
        lk_done <= 1'b0;
        lk_res <= uhct_link_t'(3'h7 ^ cnt[2:0]);
        lk_len <= {12'hFFF, ~cnt};
        if (!aresetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (tx_start) begin
            busy <= 1'b1;
            cnt <= cmd_wait;
        end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy) begin
            busy <= 1'b0;
            lk_done <= 1'b1;
            lk_res <= cmd_res;
            lk_len <= cmd_len;
        end
    end
endmodule

// *** bench/usb_host_channel_transactions_test.sv ***
// self-checking bench for the host channel transaction engine
`timescale 1ns/1ps
`include "uhct_cfg.svh"
module usb_host_channel_transactions_test;
    import uhct_pkg::*;
    // one case: channel setup, pick conditions, expected outcome
    typedef struct packed {
        logic [2:0] ch;
        logic [3:0] cfg;
        logic [7:0] mps, tot, fifo;
        logic [1:0] ok;
        logic [2:0] res;
        logic xtx;
        logic [7:0] xupd;
        logic xhs;
        logic [7:0] xsta;
    } uhct_row_s;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, sched_pick;
    logic frame_room_ok, interval_ok, tx_start, tx_token_in, tx_iso;
    logic lk_done, hs_send_ack, fifo_upd, ep_busy;
    logic [11:0] s_axi_awaddr, s_axi_araddr, base;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, cmd_wait;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [2:0] sched_chan, tx_chan, fifo_upd_chan;
    logic [15:0] fifo_valid_bytes, fifo_free_bytes, tx_len, lk_len;
    logic [15:0] fifo_upd_bytes, seen_len, upd_b, len;
    uhct_link_t lk_res, cmd_res;
    uhct_row_s rows [17];
    uhct_row_s r;
    int n_errors, checks, n_tx, n_hs, cyc;

    uhct_engine #(.NCH(6)) uut (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sched_pick, .sched_chan,
        .frame_room_ok, .interval_ok, .fifo_valid_bytes, .fifo_free_bytes,
        .tx_start, .tx_token_in, .tx_iso, .tx_chan, .tx_len, .lk_done,
        .lk_res, .lk_len, .hs_send_ack, .fifo_upd, .fifo_upd_chan,
        .fifo_upd_bytes
    );
    uhct_endpoint_model ep (
        .aclk, .aresetn, .tx_start, .cmd_res, .cmd_len(16'h0005),
        .cmd_wait, .busy(ep_busy), .lk_done, .lk_res, .lk_len
    );

    always #20 aclk = ~aclk;
    // watch the engine's pulses; a hang ends the run as a failure
    always @(posedge aclk) begin
        if (tx_start) n_tx++;
        if (tx_start) seen_len <= tx_len;
        if (hs_send_ack) n_hs++;
        if (fifo_upd) upd_b <= fifo_upd_bytes;
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // axi write: address and data together, each dropped once taken
    task automatic axw(input logic [11:0] a, input logic [31:0] v,
                       output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a, output logic [31:0] v,
                       output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // program a channel; go goes in last so the pick sees a full setup
    task automatic setup(input logic [11:0] b, input logic [7:0] m, t,
                         input logic [3:0] c);
        axw(b + 12'h004, {24'h0, m}, rsp);
        axw(b + 12'h008, {24'h0, t}, rsp);
        axw(b + 12'h00C, 32'h0000_0007, rsp);
        axw(b, {28'h0, c}, rsp);
    endtask
    // one scheduler pick, then wait out the link and the status update
    task automatic pick(input logic [2:0] c, input logic [7:0] f,
                        input logic [1:0] ok);
        n_tx = 0;
        n_hs = 0;
        upd_b = 16'h0000;
        @(posedge aclk);
        sched_pick <= 1'b1;
        sched_chan <= c;
        fifo_valid_bytes <= {8'h00, f};
        fifo_free_bytes <= {8'h00, f};
        {frame_room_ok, interval_ok} <= ok;
        @(posedge aclk);
        sched_pick <= 1'b0;
        repeat (2) @(posedge aclk);
        while (ep_busy) @(posedge aclk);
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, sched_pick, sched_chan} = '0;
        {frame_room_ok, interval_ok, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, fifo_valid_bytes, fifo_free_bytes} = '0;
        {n_errors, checks, n_tx, n_hs, cyc} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hF;
        cmd_wait = 4'h1;
        cmd_res = UHCT_LK_ACK;
        rows = '{
            '{3'h1,4'h1,8'h40,8'h30,8'hFF,2'h3,3'h0,1'b1,8'h30,1'b0,8'h01},
            '{3'h2,4'h1,8'h20,8'hFF,8'hFF,2'h3,3'h1,1'b1,8'h00,1'b0,8'h00},
            '{3'h3,4'h1,8'h40,8'h40,8'hFF,2'h3,3'h2,1'b1,8'h00,1'b0,8'h14},
            '{3'h4,4'h1,8'h40,8'h40,8'hFF,2'h3,3'h3,1'b1,8'h00,1'b0,8'h22},
            '{3'h5,4'h5,8'h10,8'h40,8'hFF,2'h3,3'h0,1'b1,8'h10,1'b0,8'h01},
            '{3'h5,4'h5,8'h10,8'h40,8'hFF,2'h2,3'h0,1'b0,8'h00,1'b0,8'h00},
            '{3'h1,4'h1,8'h40,8'h30,8'hFF,2'h1,3'h0,1'b0,8'h00,1'b0,8'h00},
            '{3'h2,4'h9,8'h40,8'h20,8'hFF,2'h3,3'h1,1'b1,8'h20,1'b0,8'h01},
            '{3'h3,4'h9,8'h40,8'h20,8'h10,2'h3,3'h0,1'b0,8'h00,1'b0,8'h52},
            '{3'h1,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h0,1'b1,8'h30,1'b1,8'h01},
            '{3'h2,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h4,1'b1,8'h05,1'b1,8'h34},
            '{3'h3,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h1,1'b1,8'h00,1'b0,8'h00},
            '{3'h4,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h2,1'b1,8'h00,1'b0,8'h14},
            '{3'h5,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h5,1'b1,8'h00,1'b0,8'h44},
            '{3'h1,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h6,1'b1,8'h00,1'b1,8'h22},
            '{3'h2,4'h3,8'h40,8'h30,8'hFF,2'h3,3'h3,1'b1,8'h00,1'b0,8'h22},
            '{3'h0,4'h3,8'h40,8'h30,8'h20,2'h3,3'h0,1'b0,8'h00,1'b0,8'h00}
        };
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // table cases; odd rows make the endpoint answer slowly
        for (int i = 0; i < 17; i++) begin
            r = rows[i];
            base = {5'h00, r.ch, 4'h0};
            len = {8'h00, (r.mps < r.tot) ? r.mps : r.tot};
            setup(base, r.mps, r.tot, r.cfg);
            cmd_res <= uhct_link_t'(r.res);
            cmd_wait <= i[0] ? 4'h9 : 4'h1;
            pick(r.ch, r.fifo, r.ok);
            chk("tx count", n_tx, {31'h0, r.xtx});
            if (r.xtx) chk("tx_len", seen_len, len);
            chk("fifo bytes", upd_b, {24'h0, r.xupd});
            chk("ack sent", n_hs, {31'h0, r.xhs});
            axr(base + 12'h00C, d, rsp);
            chk("status", d & ((r.xsta[7:4] != 4'h0) ? 32'hF7 : 32'h07),
                {24'h0, r.xsta});
            axr(base, d, rsp);
            chk("go", {31'h0, d[0]}, {31'h0, ~r.xsta[2]});
            $display("row %0d done", i);
        end
        // three retry faults in a row end the transfer
        setup(12'h040, 8'h40, 8'h40, 4'h1);
        cmd_res <= UHCT_LK_ERR;
        for (int k = 0; k < 3; k++) begin
            pick(3'h4, 8'hFF, 2'h3);
            axr(12'h040, d, rsp);
            chk("retry go", {31'h0, d[0]}, {31'h0, k < 2});
        end
        axr(12'h04C, d, rsp);
        chk("retry status", d & 32'hF7, 32'h0000_0026);
        $display("retry test done");
        // the bulk-only channel keeps no kind field
        axw(12'h000, 32'h0000_0009, rsp);
        axr(12'h000, d, rsp);
        chk("ch0 kind", d & 32'h0000_000F, 32'h0000_0001);
        axw(12'h000, 32'h0000_0000, rsp);
        // unmapped place is refused
        axw(12'h200, 32'h0000_0001, rsp);
        chk("bresp", {30'h0, rsp}, {30'h0, `UHCT_RESP_SLVERR});
        axr(12'h200, d, rsp);
        chk("rresp", {30'h0, rsp}, {30'h0, `UHCT_RESP_SLVERR});
        chk("rdata", d, 32'h0000_0000);
        $display("register test done");
        // second reset restores the channel setup
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(12'h014, d, rsp);
        chk("mps reset", d, {16'h0, `UHCT_RST_MPS});
        axr(12'h010, d, rsp);
        chk("cfg reset", d, 32'h0000_0000);
        $display("reset test done");
        conclude();
    end
endmodule
